// ==== hdl/intc_pkg.sv ====
// Purpose: shared constants and types of the interrupt and event transfer block
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes: one entry per node control, one memory entry per transfer channel
package intc_pkg;
    // ***************
    // sizes
    // ***************
    localparam int NODES = 16;
    localparam int CHANS = 8;
    localparam int EXTS = 4;
    localparam int EXT_NODE0 = 12;

    // ***************
    // register map
    // ***************
    localparam logic [7:0] OFF_STAT = 8'h40;
    localparam logic [7:0] OFF_MASK = 8'h44;
    localparam logic [7:0] OFF_CFG = 8'h48;
    localparam logic [7:0] OFF_STATE = 8'h4c;
    localparam logic [1:0] CF_SRC = 2'h0;
    localparam logic [1:0] CF_DST = 2'h1;
    localparam logic [1:0] CF_CNT = 2'h2;
    localparam logic [1:0] CF_CTL = 2'h3;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic JC_RST = 1'h0;

    // ***************
    // timing and vectors
    // ***************
    localparam logic [3:0] RESP_JC_CYC = 4'h7;
    localparam logic [3:0] RESP_NJC_CYC = 4'hb;
    localparam logic [7:0] TRAP_BASE = 8'h10;

    typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_t;

    typedef struct packed {
        logic [2:0] ch;
        logic use_ch;
        logic [3:0] prio;
        logic en;
        logic req;
    } node_t;

    typedef struct packed {
        logic cont;
        logic incd;
        logic incs;
        logic word;
    } ch_ctl_t;

    typedef struct packed {
        ch_ctl_t ctl;
        logic [7:0] cnt;
        logic [15:0] dst;
        logic [15:0] src;
    } ch_entry_t;

    typedef struct packed {
        logic req;
        logic [15:0] vec;
        logic [3:0] prio;
    } cpu_req_t;

    typedef struct packed {
        logic stb;
        logic word;
        logic [15:0] src;
        logic [15:0] dst;
    } xfer_t;

    // vector offset is trap number times four
    function automatic logic [15:0] vec_of(input logic [7:0] t);
        return {6'h00, t, 2'h0};
    endfunction : vec_of
endpackage : intc_pkg

// ==== hdl/ext_edge.sv ====
// Purpose: synchronise fast external inputs and detect the selected edges
// Assumes: pins are asynchronous to clk
// Notes: one pulse per detected edge, two cycles of sync latency
`timescale 1ns/1ps
module ext_edge (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins and edge selection
    input wire logic [intc_pkg::EXTS-1:0] pin,
    input wire intc_pkg::edge_sel_t [intc_pkg::EXTS-1:0] sel,
    // one-cycle edge pulses
    output logic [intc_pkg::EXTS-1:0] pulse
);
    import intc_pkg::*;

    typedef struct packed {
        logic [EXTS-1:0] s1;
        logic [EXTS-1:0] s2;
        logic [EXTS-1:0] prev;
        logic [EXTS-1:0] pulse;
    } edge_state_t;

    edge_state_t r_reg;
    edge_state_t r_next;
    logic [EXTS-1:0] hit;

    // per pin edge match
    for (genvar g = 0; g < EXTS; g++) begin : g_edge
        assign hit[g] = (r_reg.s2[g] & ~r_reg.prev[g] & sel[g][0])
                      | (~r_reg.s2[g] & r_reg.prev[g] & sel[g][1]); // see R12
    end

    // sync chain and pulse register
    always_comb begin
        r_next = r_reg;
        r_next.s1 = pin;
        r_next.s2 = r_reg.s1;
        r_next.prev = r_reg.s2;
        r_next.pulse = hit;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign pulse = r_reg.pulse;

    a_edge_rise: assert property (@(posedge clk) disable iff (!rst_n) // see R12
        (r_reg.s2[0] && !r_reg.prev[0] && sel[0] == EDGE_RISE) |=> pulse[0])
        else $error("rising edge not reported");
endmodule : ext_edge

// ==== hdl/ch_mem.sv ====
// Purpose: storage of pointers, counters and modes of the transfer channels
// Assumes: one port, read data registered
// Notes: each field has its own write enable
`timescale 1ns/1ps
module ch_mem (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // access port
    input wire logic [2:0] addr,
    input wire logic [3:0] we,
    input wire intc_pkg::ch_entry_t wdata,
    output intc_pkg::ch_entry_t rdata
);
    import intc_pkg::*;

    ch_entry_t mem [CHANS];

    // field writes
    always_ff @(posedge clk) begin
        if (we[CF_SRC]) begin
            mem[addr].src <= wdata.src;
        end
        if (we[CF_DST]) begin
            mem[addr].dst <= wdata.dst;
        end
        if (we[CF_CNT]) begin
            mem[addr].cnt <= wdata.cnt;
        end
        if (we[CF_CTL]) begin
            mem[addr].ctl <= wdata.ctl;
        end
    end

    // registered read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= mem[addr];
        end
    end
endmodule : ch_mem

// ==== hdl/intc_top.sv ====
// Purpose: prioritised interrupt nodes with eight event transfer channels
// Assumes: peripheral requests on MCLK; external pins asynchronous
// Notes: registers over classic Wishbone; accesses served while idle
//
// Operation
// R1 - the service routine entry strobe comes 7 clocks after acceptance with jump cache, else 11.
// R2 - each node chooses standard interrupt service or an event transfer channel.
// R3 - standard service vectors the CPU while a transfer steals exactly one cycle.
// R4 - a transfer moves a byte or word then bumps source, destination or both.
// R5 - each transfer decrements the channel counter unless continuous mode is set; the code holds a counter already at zero at zero.
// R6 - a counter reaching zero turns the node's request into a standard interrupt.
// R7 - there are eight independent transfer channels.
// R8 - every node owns a control register with request, enable and priority.
// R9 - sixteen priority levels arbitrate among pending requests.
// R10 - a standard request is passed on only above the level the CPU runs at.
// R11 - each node has its own vector at its trap number times four.
// R12 - fast external inputs raise requests on a selected rising, falling or both edges.
// R13 - a software trap with a number vectors to that number's location.
// R14 - software may raise a node request by setting its request bit.
// R15 - acceptance clears the request bit and only enabled nodes are forwarded.
`timescale 1ns/1ps
module intc_top (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // request sources
    input wire logic [intc_pkg::NODES-1:0] SRC_REQ,
    input wire logic [intc_pkg::EXTS-1:0] EXT_PIN,
    // cpu side
    input wire logic [3:0] CPU_LEVEL,
    input wire logic CPU_ACK,
    input wire logic TRAP_REQ,
    input wire logic [7:0] TRAP_NUM,
    output intc_pkg::cpu_req_t CPU_REQ,
    output logic ENTRY,
    // transfer bus
    output intc_pkg::xfer_t XFER,
    // interrupt
    output logic IRQ
);
    import intc_pkg::*;

    // ***************
    // state
    // ***************
    typedef enum logic [2:0] {S_IDLE, S_WBMEM, S_CHRD, S_CHXF, S_WAIT, S_ENTRY} fsm_t;

    typedef struct packed {
        fsm_t fsm;
        node_t [NODES-1:0] node;
        logic [NODES-1:0] fstd;
        logic [CHANS-1:0] stat;
        logic [CHANS-1:0] mask;
        logic jc;
        edge_sel_t [EXTS-1:0] esel;
        logic [3:0] cur;
        logic [2:0] ch;
        logic [3:0] cnt;
        logic tpend;
        logic [7:0] tnum;
        cpu_req_t req;
        logic entry;
        xfer_t xf;
        logic ack;
        logic [31:0] dat;
        logic irq;
    } state_t;

    state_t r_reg;
    state_t r_next;
    logic [EXTS-1:0] ext_pulse;
    logic [NODES-1:0] ev;
    logic [2:0] mem_addr;
    logic [3:0] mem_we;
    ch_entry_t mem_wd;
    ch_entry_t rd;
    logic best_v;
    logic [3:0] best_i;
    logic [3:0] best_p;
    logic wb_go;
    logic wr;
    logic [7:0] cnt_new;
    logic [15:0] step;
    logic [3:0] resp_m1;

    // ***************
    // leaves
    // ***************
    ext_edge u_edge (
        .clk(MCLK),
        .rst_n(RESETN),
        .pin(EXT_PIN),
        .sel(r_reg.esel),
        .pulse(ext_pulse)
    );

    ch_mem u_mem (
        .clk(MCLK),
        .rst_n(RESETN),
        .addr(mem_addr),
        .we(mem_we),
        .wdata(mem_wd),
        .rdata(rd)
    );

    // ***************
    // arbitration
    // ***************
    // highest priority enabled request, lowest index on a tie
    always_comb begin
        best_v = 1'b0;
        best_i = 4'h0;
        best_p = 4'h0;
        for (int i = 0; i < NODES; i++) begin
            if (r_reg.node[i].req && r_reg.node[i].en // see R15
                && (!best_v || r_reg.node[i].prio > best_p)) begin // see R9
                best_v = 1'b1;
                best_i = 4'(i);
                best_p = r_reg.node[i].prio;
            end
        end
    end

    // hardware request events, external pins on the upper nodes
    always_comb begin
        ev = SRC_REQ;
        ev[EXT_NODE0 +: EXTS] = SRC_REQ[EXT_NODE0 +: EXTS] | ext_pulse; // see R12
    end

    assign wb_go = WB_CYC_I & WB_STB_I & ~r_reg.ack & (r_reg.fsm == S_IDLE);
    assign wr = wb_go & WB_WE_I & WB_SEL_I[0];
    assign resp_m1 = (r_reg.jc ? RESP_JC_CYC : RESP_NJC_CYC) - 4'h1; // see R1
    assign step = rd.ctl.word ? 16'h0002 : 16'h0001;
    assign cnt_new = (rd.ctl.cont || rd.cnt == 8'h00) ? rd.cnt : rd.cnt - 8'h01; // see R5

    // ***************
    // next state
    // ***************
    always_comb begin
        r_next = r_reg;
        r_next.ack = 1'b0;
        r_next.entry = 1'b0;
        r_next.xf.stb = 1'b0;
        mem_addr = r_reg.ch;
        mem_we = 4'h0;
        mem_wd = rd;
        if (r_reg.fsm == S_IDLE || r_reg.fsm == S_WBMEM) begin
            mem_addr = WB_ADR_I[6:4];
        end
        case (r_reg.fsm)
            S_IDLE: begin
                if (wb_go) begin
                    r_next.ack = 1'b1;
                    r_next.dat = 32'h0;
                    if (WB_ADR_I[7]) begin
                        // channel field, whole field written from low lanes
                        mem_wd = '{ctl: WB_DAT_I[3:0], cnt: WB_DAT_I[7:0],
                                   dst: WB_DAT_I[15:0], src: WB_DAT_I[15:0]};
                        mem_we[WB_ADR_I[3:2]] = wr;
                        if (!WB_WE_I) begin
                            r_next.ack = 1'b0;
                            r_next.fsm = S_WBMEM;
                        end
                    end else if (WB_ADR_I[6] == 1'b0) begin
                        if (wr) begin
                            r_next.node[WB_ADR_I[5:2]] = node_t'(WB_DAT_I[9:0]); // see R8 R14
                        end
                        r_next.dat = 32'(r_reg.node[WB_ADR_I[5:2]]);
                    end else begin
                        case (WB_ADR_I)
                            OFF_STAT: begin
                                if (wr) begin
                                    r_next.stat = r_reg.stat & ~WB_DAT_I[7:0];
                                end
                                r_next.dat = 32'(r_reg.stat);
                            end
                            OFF_MASK: begin
                                if (wr) begin
                                    r_next.mask = WB_DAT_I[7:0];
                                end
                                r_next.dat = 32'(r_reg.mask);
                            end
                            OFF_CFG: begin
                                if (wr) begin
                                    r_next.jc = WB_DAT_I[0];
                                    r_next.esel = WB_DAT_I[8:1];
                                end
                                r_next.dat = 32'({r_reg.esel, r_reg.jc});
                            end
                            OFF_STATE: begin
                                r_next.dat = 32'({r_reg.tpend, r_reg.fsm, r_reg.cur});
                            end
                            default: begin
                                r_next.dat = 32'h0;
                            end
                        endcase
                    end
                end else if (r_reg.tpend) begin
                    // software trap enters at its own vector
                    r_next.tpend = 1'b0;
                    r_next.req.vec = vec_of(r_reg.tnum); // see R13
                    r_next.cnt = resp_m1;
                    r_next.fsm = S_ENTRY;
                end else if (best_v && r_reg.node[best_i].use_ch
                             && !r_reg.fstd[best_i]) begin // see R2
                    r_next.node[best_i].req = 1'b0; // see R15
                    r_next.cur = best_i;
                    r_next.ch = r_reg.node[best_i].ch; // see R7
                    r_next.fsm = S_CHRD;
                end else if (best_v && best_p > CPU_LEVEL) begin // see R10
                    r_next.cur = best_i;
                    r_next.req.req = 1'b1;
                    r_next.req.prio = best_p;
                    r_next.req.vec = vec_of(8'(TRAP_BASE + {4'h0, best_i})); // see R11
                    r_next.fsm = S_WAIT;
                end
            end
            S_WBMEM: begin
                // registered memory read now valid
                r_next.ack = 1'b1;
                r_next.fsm = S_IDLE;
                case (WB_ADR_I[3:2])
                    CF_SRC: r_next.dat = 32'(rd.src);
                    CF_DST: r_next.dat = 32'(rd.dst);
                    CF_CNT: r_next.dat = 32'(rd.cnt);
                    default: r_next.dat = 32'(rd.ctl);
                endcase
            end
            S_CHRD: begin
                r_next.fsm = S_CHXF;
            end
            S_CHXF: begin
                // one stolen cycle, pointer and counter written back on the same edge
                r_next.xf = '{stb: 1'b1, word: rd.ctl.word, src: rd.src, dst: rd.dst}; // see R3
                mem_wd.src = rd.ctl.incs ? rd.src + step : rd.src; // see R4
                mem_wd.dst = rd.ctl.incd ? rd.dst + step : rd.dst; // see R4
                mem_wd.cnt = cnt_new;
                mem_we = 4'h7;
                if (!rd.ctl.cont && cnt_new == 8'h00) begin
                    r_next.node[r_reg.cur].req = 1'b1; // see R6
                    r_next.fstd[r_reg.cur] = 1'b1;
                    r_next.stat[r_reg.ch] = 1'b1;
                end
                r_next.fsm = S_IDLE;
            end
            S_WAIT: begin
                if (CPU_ACK) begin
                    r_next.req.req = 1'b0;
                    r_next.node[r_reg.cur].req = 1'b0; // see R15
                    r_next.fstd[r_reg.cur] = 1'b0;
                    r_next.cnt = resp_m1;
                    r_next.fsm = S_ENTRY;
                end
            end
            S_ENTRY: begin
                if (r_reg.cnt == 4'h0) begin
                    r_next.entry = 1'b1; // see R1
                    r_next.fsm = S_IDLE;
                end else begin
                    r_next.cnt = r_reg.cnt - 4'h1;
                end
            end
            default: begin
                r_next.fsm = S_IDLE;
            end
        endcase
        // events win over any clear in the same cycle
        for (int i = 0; i < NODES; i++) begin
            if (ev[i]) begin
                r_next.node[i].req = 1'b1;
            end
        end
        if (TRAP_REQ) begin
            r_next.tpend = 1'b1;
            r_next.tnum = TRAP_NUM;
        end
        r_next.irq = |(r_next.stat & r_next.mask);
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            r_reg <= '0;
            r_reg.mask <= MASK_RST;
            r_reg.jc <= JC_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from the state register
    assign WB_DAT_O = r_reg.dat;
    assign WB_ACK_O = r_reg.ack;
    assign CPU_REQ = r_reg.req;
    assign ENTRY = r_reg.entry;
    assign XFER = r_reg.xf;
    assign IRQ = r_reg.irq;

    // ***************
    // checks
    // ***************
    sequence s_accept;
        r_reg.fsm == S_WAIT && CPU_ACK;
    endsequence

    sequence s_xfer;
        r_reg.fsm == S_CHXF;
    endsequence

    a_entry_jc: assert property (@(posedge MCLK) disable iff (!RESETN) // see R1
        (s_accept and r_reg.jc) |=> (!ENTRY)[*7] ##1 ENTRY)
        else $error("entry not 7 clocks after accept");

    a_entry_njc: assert property (@(posedge MCLK) disable iff (!RESETN) // see R1
        (s_accept and !r_reg.jc) |=> (!ENTRY)[*8] ##1 !ENTRY ##1 !ENTRY ##1 !ENTRY ##1 ENTRY)
        else $error("entry not 11 clocks after accept");

    a_steal_one: assert property (@(posedge MCLK) disable iff (!RESETN) // see R3
        s_xfer |=> XFER.stb ##1 !XFER.stb)
        else $error("transfer did not steal exactly one cycle");

    a_ptr_step: assert property (@(posedge MCLK) disable iff (!RESETN) // see R4
        (s_xfer and rd.ctl.incs) |-> mem_we[CF_SRC] && mem_wd.src == rd.src + step)
        else $error("source pointer not advanced");

    a_cnt_dec: assert property (@(posedge MCLK) disable iff (!RESETN) // see R5
        (s_xfer and !rd.ctl.cont && rd.cnt != 8'h00) |-> mem_wd.cnt == rd.cnt - 8'h01)
        else $error("transfer counter not decremented");

    a_zero_std: assert property (@(posedge MCLK) disable iff (!RESETN) // see R6
        (s_xfer and !rd.ctl.cont && rd.cnt == 8'h01) |=> r_reg.stat[$past(r_reg.ch)]
        && r_reg.fstd[$past(r_reg.cur)] && r_reg.node[$past(r_reg.cur)].req)
        else $error("expired counter did not raise standard request");

    a_level_gate: assert property (@(posedge MCLK) disable iff (!RESETN) // see R10
        $rose(CPU_REQ.req) |-> CPU_REQ.prio > $past(CPU_LEVEL)
        && CPU_REQ.vec == vec_of(8'(TRAP_BASE + {4'h0, r_reg.cur})))
        else $error("request forwarded without higher priority or bad vector");

    a_accept_clr: assert property (@(posedge MCLK) disable iff (!RESETN) // see R15
        (s_accept and !ev[r_reg.cur]) |=> !r_reg.node[$past(r_reg.cur)].req && !CPU_REQ.req)
        else $error("accepted request not cleared");
endmodule : intc_top

// ==== sim/cpu_model.sv ====
// Purpose: behavioural cpu core that accepts requests and times routine entry
// Assumes: request held until the accepting edge
// Notes: acceptance delay chosen by the bench, zero for prompt
`timescale 1ns/1ps
module cpu_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // controller side
    input wire intc_pkg::cpu_req_t req,
    input wire logic entry,
    input wire logic [3:0] delay,
    input wire logic trap,
    // acceptance and observations
    output logic ack,
    output logic [15:0] got_vec,
    output logic [3:0] resp,
    output int n_ent
);
    import intc_pkg::*;
    logic [3:0] wait_reg;
    logic [3:0] cnt_reg;
    // accept a raised request after the chosen delay, one-cycle pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            wait_reg <= 4'h0;
        end else if (req.req && !ack && wait_reg >= delay) begin
            ack <= 1'b1;
            wait_reg <= 4'h0;
        end else if (req.req && !ack) begin
            wait_reg <= wait_reg + 4'h1;
        end else begin
            ack <= 1'b0;
            wait_reg <= 4'h0;
        end
    end
    // clocks from acceptance to routine entry, vector taken at entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 4'h0;
            resp <= 4'h0;
            n_ent <= 0;
            got_vec <= 16'h0000;
        end else if (ack && req.req) begin
            cnt_reg <= 4'h0;
        end else if (trap) begin
            // a trap is taken at the edge after its request registers
            cnt_reg <= 4'hf;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
            if (entry) begin
                resp <= cnt_reg;
                got_vec <= req.vec;
                n_ent <= n_ent + 1;
            end
        end
    end
endmodule : cpu_model

// ==== sim/tb.sv ====
// Purpose: self-checking bench of the interrupt and transfer block
// Assumes: classic wishbone master, cpu model on the far side
// Notes: expectations built from the register map and vector rule
`timescale 1ns/1ps
module tb;
    import intc_pkg::*;
    logic MCLK, RESETN, cyc, stb, we, trap, ack, entry, irq, cack;
    logic [7:0] adr, tnum;
    logic [3:0] sel, lvl, dly, resp;
    logic [31:0] dat, rdat, q;
    logic [15:0] src, gvec;
    logic [3:0] ext;
    cpu_req_t creq;
    xfer_t xf;
    int n_ent, seen, error_cnt, checks;

    intc_top DUT (.MCLK(MCLK), .RESETN(RESETN), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .SRC_REQ(src), .EXT_PIN(ext), .CPU_LEVEL(lvl), .CPU_ACK(cack), .TRAP_REQ(trap),
        .TRAP_NUM(tnum), .CPU_REQ(creq), .ENTRY(entry), .XFER(xf), .IRQ(irq));
    cpu_model CPU (.clk(MCLK), .rst_n(RESETN), .req(creq), .entry(entry), .delay(dly),
        .trap(trap), .ack(cack), .got_vec(gvec), .resp(resp), .n_ent(n_ent));

    // 20 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end

    // ***************
    // helpers
    // ***************
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk
    task hang(input string nm);
        $display("mismatch %s expected event seen timeout", nm);
        error_cnt++;
        give_verdict();
    endtask : hang
    // one classic cycle, held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge MCLK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge MCLK);
            i++;
        end while (ack !== 1'b1 && i < 300);
        if (ack !== 1'b1) hang("bus ack");
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask : rchk
    task pulse(input logic [15:0] m);
        @(posedge MCLK);
        src <= m;
        @(posedge MCLK);
        src <= 16'h0000;
    endtask : pulse
    task serve(input string nm, input logic [15:0] v, input logic [3:0] r);
        int i;
        for (i = 0; i < 200 && n_ent == seen; i++) @(posedge MCLK);
        if (n_ent == seen) hang(nm);
        seen = n_ent;
        chk({nm, " vector"}, v, gvec);
        chk({nm, " entry delay"}, r, resp);
    endtask : serve
    task quiet(input int n);
        logic hit;
        hit = 1'b0;
        repeat (n) begin
            @(posedge MCLK);
            if (creq.req !== 1'b0) hit = 1'b1;
        end
        chk("no request", 0, hit);
    endtask : quiet
    task xwait(input logic [15:0] s, input logic [15:0] d, input logic w);
        int i;
        for (i = 0; i < 50 && xf.stb !== 1'b1; i++) @(posedge MCLK);
        if (xf.stb !== 1'b1) hang("transfer");
        chk("xfer src", s, xf.src);
        chk("xfer dst", d, xf.dst);
        chk("xfer width", w, xf.word);
    endtask : xwait
    task chan(input logic [7:0] b, input logic [15:0] s, input logic [15:0] d,
              input logic [7:0] n, input logic [3:0] c);
        wb(1'b1, b, {16'h0, s});
        wb(1'b1, b + 8'h4, {16'h0, d});
        wb(1'b1, b + 8'h8, {24'h0, n});
        wb(1'b1, b + 8'hc, {28'h0, c});
    endtask : chan
    function automatic logic [31:0] nd(input logic [3:0] p, input logic e, input logic u,
                                       input logic [2:0] c);
        return {22'h0, c, u, p, e, 1'b0};
    endfunction : nd

    // ***************
    // tests
    // ***************
    initial begin
        RESETN = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
        dat = 32'h0; src = 16'h0; ext = 4'h0; lvl = 4'h0; trap = 1'b0; tnum = 8'h00;
        dly = 4'h0; seen = 0; error_cnt = 0; checks = 0;
        repeat (16) @(posedge MCLK);
        RESETN <= 1'b1;
        chk("irq idle", 0, irq);
        rchk("mask", OFF_MASK, {24'h0, MASK_RST});
        wb(1'b0, OFF_CFG, 32'h0);
        chk("jump cache", JC_RST, q[0]);
        wb(1'b1, 8'h60, 32'hffffffff);
        rchk("unmapped", 8'h60, 32'h0);
        $display("test reset done");
        wb(1'b1, 8'h14, nd(4'h3, 1'b1, 1'b0, 3'h0));
        pulse(16'h0020);
        serve("node 5", 16'h0054, RESP_NJC_CYC);
        rchk("node 5 control", 8'h14, nd(4'h3, 1'b1, 1'b0, 3'h0));
        wb(1'b1, OFF_CFG, 32'h1);
        wb(1'b1, 8'h04, nd(4'h2, 1'b1, 1'b0, 3'h0));
        wb(1'b1, 8'h08, nd(4'h5, 1'b1, 1'b0, 3'h0));
        dly <= 4'h5;
        pulse(16'h0006);
        serve("node 2", 16'h0048, RESP_JC_CYC);
        dly <= 4'h0;
        serve("node 1", 16'h0044, RESP_JC_CYC);
        $display("test standard service done");
        lvl <= 4'h3;
        wb(1'b1, 8'h24, nd(4'h3, 1'b1, 1'b0, 3'h0));
        wb(1'b1, 8'h28, nd(4'h9, 1'b0, 1'b0, 3'h0));
        pulse(16'h0600);
        quiet(20);
        wb(1'b1, 8'h24, nd(4'h4, 1'b1, 1'b0, 3'h0) | 32'h1);
        serve("node 9", 16'h0064, RESP_JC_CYC);
        lvl <= 4'h0;
        wb(1'b1, 8'h1c, nd(4'h1, 1'b1, 1'b0, 3'h0) | 32'h1);
        serve("software", 16'h005c, RESP_JC_CYC);
        @(posedge MCLK);
        trap <= 1'b1;
        tnum <= 8'h28;
        @(posedge MCLK);
        trap <= 1'b0;
        serve("trap", 16'h00a0, RESP_JC_CYC);
        $display("test level and trap done");
        chan(8'ha0, 16'h1000, 16'h2000, 8'h02, 4'h7);
        wb(1'b1, 8'h10, nd(4'h2, 1'b1, 1'b1, 3'h2));
        pulse(16'h0010);
        xwait(16'h1000, 16'h2000, 1'b1);
        rchk("count", 8'ha8, 32'h1);
        rchk("src step", 8'ha0, 32'h1002);
        rchk("dst step", 8'ha4, 32'h2002);
        pulse(16'h0010);
        xwait(16'h1002, 16'h2002, 1'b1);
        serve("expired", 16'h0050, RESP_JC_CYC);
        rchk("status", OFF_STAT, 32'h4);
        chk("irq masked", 0, irq);
        wb(1'b1, OFF_MASK, 32'h4);
        repeat (2) @(posedge MCLK);
        chk("irq unmasked", 1, irq);
        wb(1'b1, OFF_STAT, 32'h4);
        repeat (2) @(posedge MCLK);
        chk("irq cleared", 0, irq);
        chan(8'h80, 16'h0100, 16'h0200, 8'h05, 4'ha);
        wb(1'b1, 8'h0c, nd(4'h1, 1'b1, 1'b1, 3'h0));
        pulse(16'h0008);
        xwait(16'h0100, 16'h0200, 1'b0);
        rchk("continuous count", 8'h88, 32'h5);
        rchk("byte src", 8'h80, 32'h101);
        rchk("fixed dst", 8'h84, 32'h200);
        $display("test transfer channels done");
        wb(1'b1, 8'h30, nd(4'h1, 1'b1, 1'b0, 3'h0));
        wb(1'b1, OFF_CFG, 32'h3);
        @(posedge MCLK);
        ext <= 4'h1;
        serve("rising pin", 16'h0070, RESP_JC_CYC);
        @(posedge MCLK);
        ext <= 4'h0;
        quiet(10);
        wb(1'b1, OFF_CFG, 32'h5);
        @(posedge MCLK);
        ext <= 4'h1;
        quiet(10);
        ext <= 4'h0;
        serve("falling pin", 16'h0070, RESP_JC_CYC);
        $display("test external edges done");
        give_verdict();
    end
endmodule : tb
